// [src/paf_pin_setup_host.sv]
// module: host that programs a device's pins for alternate functions
`timescale 1ns/1ps
module paf_pin_setup_host
  import paf_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] swAddr,
  input wire logic [31:0] swWrData,
  input wire logic swWrite,
  input wire logic swRead,
  output logic [31:0] swRdData,
  output logic [15:0] devAddr,
  output logic [7:0] devWrData,
  output logic devWrite,
  output logic devRead,
  input wire logic [7:0] devRdData
);

  // one read-modify-write step: valid, address, mask, value
  function automatic logic [32:0] step_desc(
    input logic [3:0] fn,
    input logic [3:0] port,
    input logic [2:0] pin,
    input logic opt,
    input logic [1:0] step
  );
    logic [15:0] latchAddr;
    logic [15:0] dirAddr;
    logic [7:0] bm;
    logic [32:0] r;
    latchAddr = LATCH_BASE + {12'h000, port};
    dirAddr = DIR_BASE + {12'h000, port};
    bm = 8'h01 << pin;
    r = 33'h0_0000_0000;
    case (fn)
      // latch is written before direction so the pin never glitches
      FN_OUT_DIRECT: begin
        if (step == 2'h0) begin
          r = {1'b1, latchAddr, bm, 8'h00};
        end else if (step == 2'h1) begin
          r = {1'b1, dirAddr, bm, 8'h00};
        end
      end
      FN_INPUT: begin
        if (step == 2'h0) begin
          r = {1'b1, dirAddr, bm, 8'hFF};
        end
      end
      FN_ASYNC_TX: begin
        if (step == 2'h0) begin
          r = {1'b1, latchAddr, bm, 8'hFF};
        end else if (step == 2'h1) begin
          r = {1'b1, dirAddr, bm, 8'h00};
        end
      end
      FN_SERIAL_BUS: begin
        if (step == 2'h0) begin
          r = {1'b1, ADDR_PORT_OUTPUT_MODE, SERIAL_BUS_MASK,
               8'hFF};
        end else if (step == 2'h1) begin
          r = {1'b1, ADDR_PORT_INPUT_MODE, SERIAL_BUS_MASK,
               opt ? 8'hFF : 8'h00};
        end else if (step == 2'h2) begin
          r = {1'b1, LATCH_BASE + {12'h000, SERIAL_BUS_PORT},
               SERIAL_BUS_MASK, 8'hFF};
        end else begin
          r = {1'b1, DIR_BASE + {12'h000, SERIAL_BUS_PORT},
               SERIAL_BUS_MASK, 8'h00};
        end
      end
      // opt 0 resonator, opt 1 external clock; direction/latch untouched
      FN_MAIN_CLOCK: begin
        if (step == 2'h0) begin
          r = {1'b1, ADDR_CLOCK_PIN_MODE, MAIN_EXT_MASK | MAIN_OSC_MASK,
               opt ? 8'hFF : MAIN_OSC_MASK};
        end
      end
      FN_SUB_CLOCK: begin
        if (step == 2'h0) begin
          r = {1'b1, ADDR_CLOCK_PIN_MODE, SUB_EXT_MASK | SUB_OSC_MASK,
               opt ? 8'hFF : SUB_OSC_MASK};
        end
      end
      // opt 0 keeps the pin as reset input, opt 1 makes it an input port
      FN_RESET_PIN: begin
        if (step == 2'h0) begin
          r = {1'b1, ADDR_RESET_PIN_MODE, RESET_PIN_FN_MASK,
               opt ? 8'hFF : 8'h00};
        end
      end
      FN_RELOCATE: begin
        if (step == 2'h0) begin
          r = {1'b1, ADDR_PIN_RELOCATION, RELOCATION_MASK,
               opt ? 8'hFF : 8'h00};
        end
      end
      // input mode first, then switch the pin to analog (config bit 0)
      FN_ANALOG: begin
        if (step == 2'h0) begin
          r = {1'b1, dirAddr, bm, 8'hFF};
        end else if (step == 2'h1) begin
          r = {1'b1, (port == ANALOG_PORT_B) ? ADDR_ANALOG_CFG_B
               : ADDR_ANALOG_CFG_A, bm, 8'h00};
        end
      end
      default: begin
        r = 33'h0_0000_0000;
      end
    endcase
    return r;
  endfunction

  paf_state_type state_reg;
  paf_state_type state_next;
  logic [3:0] func_reg;
  logic [3:0] port_reg;
  logic [2:0] pin_reg;
  logic opt_reg;
  logic [1:0] step_reg;
  logic done_reg;
  logic err_reg;
  logic [7:0] last_reg;
  logic [15:0] addr_reg;
  logic [7:0] mask_reg;
  logic [7:0] val_reg;
  logic [7:0] wdata_reg;
  logic rdValid_reg;
  logic [31:0] rdData_reg;

  // software decode
  wire ctrlWrite = swWrite && (swAddr == SW_CTRL);
  wire statWrite = swWrite && (swAddr == SW_STATUS);
  wire startReq = ctrlWrite && swWrData[CTRL_START_BIT];
  wire [3:0] reqFunc = swWrData[CTRL_FUNC_LSB +: 4];
  wire reqPortOk = (reqFunc != FN_ANALOG) ||
    (swWrData[CTRL_PORT_LSB +: 4] == ANALOG_PORT_A) ||
    (swWrData[CTRL_PORT_LSB +: 4] == ANALOG_PORT_B);
  wire reqOk = (reqFunc <= FN_LAST) && reqPortOk;
  wire busy = (state_reg != ST_IDLE);
  wire accept = startReq && !busy && reqOk;
  wire reject = startReq && !busy && !reqOk;
  wire doneClear = statWrite && swWrData[STAT_DONE_BIT];
  wire errClear = statWrite && swWrData[STAT_ERR_BIT];

  // current step of the running command
  wire [32:0] desc = step_desc(func_reg, port_reg, pin_reg, opt_reg,
    step_reg);
  wire stepValid = desc[32];
  wire lastStep = (step_reg == 2'h3);
  // a four-step command ends from its last write, the others from load
  wire finish = ((state_reg == ST_LOAD) && !stepValid) ||
    ((state_reg == ST_WRITE) && lastStep);
  wire [7:0] merged = (devRdData & ~mask_reg) | (val_reg & mask_reg);

  wire [31:0] statusWord = {24'h000000, 2'b00, step_reg, 1'b0, err_reg,
    done_reg, busy};
  wire [31:0] ctrlWord = {16'h0000, opt_reg, pin_reg, port_reg, func_reg,
    4'h0};
  wire [31:0] rdMux = (swAddr == SW_CTRL) ? ctrlWord
    : (swAddr == SW_STATUS) ? statusWord
    : (swAddr == SW_LAST) ? {24'h000000, last_reg}
    : 32'h00000000;

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: begin
        state_next = stepValid ? ST_WAIT : ST_IDLE;
      end
      ST_WAIT: begin
        state_next = ST_MODIFY;
      end
      ST_MODIFY: begin
        state_next = ST_WRITE;
      end
      ST_WRITE: begin
        state_next = lastStep ? ST_IDLE : ST_LOAD;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // command capture and step tracking
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      func_reg <= 4'h0;
      port_reg <= 4'h0;
      pin_reg <= 3'h0;
      opt_reg <= 1'b0;
      step_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (accept) begin
        func_reg <= reqFunc;
        port_reg <= swWrData[CTRL_PORT_LSB +: 4];
        pin_reg <= swWrData[CTRL_PIN_LSB +: 3];
        opt_reg <= swWrData[CTRL_OPT_BIT];
        step_reg <= 2'h0;
      end else if (state_reg == ST_WRITE) begin
        step_reg <= step_reg + 2'h1;
      end
    end
  end

  // device access: read the register, merge the field, write it back
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      addr_reg <= 16'h0000;
      mask_reg <= 8'h00;
      val_reg <= 8'h00;
      wdata_reg <= 8'h00;
      last_reg <= 8'h00;
      devRead <= 1'b0;
      devWrite <= 1'b0;
    end else begin
      devRead <= (state_next == ST_WAIT);
      devWrite <= (state_next == ST_WRITE);
      if ((state_reg == ST_LOAD) && stepValid) begin
        addr_reg <= desc[31:16];
        mask_reg <= desc[15:8];
        val_reg <= desc[7:0];
      end
      if (state_reg == ST_MODIFY) begin
        wdata_reg <= merged;
        last_reg <= devRdData;
      end
    end
  end

  // sticky flags: a hardware set wins over a software clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      done_reg <= finish || (done_reg && !doneClear);
      err_reg <= reject || (err_reg && !errClear);
    end
  end

  // software read data, one cycle after the strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdValid_reg <= 1'b0;
      rdData_reg <= 32'h00000000;
    end else begin
      rdValid_reg <= swRead;
      if (swRead) begin
        rdData_reg <= rdMux;
      end
    end
  end

  assign swRdData = rdValid_reg ? rdData_reg : 32'h00000000;
  assign devAddr = addr_reg;
  assign devWrData = wdata_reg;

endmodule

// [src/paf_pkg.sv]
// package: device map, command codes and field layout for the pin setup host
package paf_pkg;
  // device side: port latch n at LATCH_BASE+n, direction n at DIR_BASE+n
  localparam logic [15:0] LATCH_BASE = 16'hFF00;
  localparam logic [15:0] DIR_BASE = 16'hFF20;
  localparam logic [15:0] ADDR_PORT_INPUT_MODE = 16'hFF29;
  localparam logic [15:0] ADDR_PORT_OUTPUT_MODE = 16'hFF2A;
  localparam logic [15:0] ADDR_RESET_PIN_MODE = 16'hFF2D;
  localparam logic [15:0] ADDR_ANALOG_CFG_A = 16'hFF2E;
  localparam logic [15:0] ADDR_ANALOG_CFG_B = 16'hFF2F;
  localparam logic [15:0] ADDR_PIN_RELOCATION = 16'hFF3F;
  localparam logic [15:0] ADDR_CLOCK_PIN_MODE = 16'hFF9F;
  // bit masks inside device registers
  localparam logic [7:0] RESET_PIN_FN_MASK = 8'h20;
  localparam logic [7:0] RELOCATION_MASK = 8'h04;
  localparam logic [7:0] MAIN_EXT_MASK = 8'h80;
  localparam logic [7:0] MAIN_OSC_MASK = 8'h40;
  localparam logic [7:0] SUB_EXT_MASK = 8'h20;
  localparam logic [7:0] SUB_OSC_MASK = 8'h10;
  // serial bus pins sit on port 6, bits 0 and 1
  localparam logic [3:0] SERIAL_BUS_PORT = 4'h6;
  localparam logic [7:0] SERIAL_BUS_MASK = 8'h03;
  // analog ports
  localparam logic [3:0] ANALOG_PORT_A = 4'h2;
  localparam logic [3:0] ANALOG_PORT_B = 4'h1;
  // host software registers (byte offsets)
  localparam logic [7:0] SW_CTRL = 8'h00;
  localparam logic [7:0] SW_STATUS = 8'h04;
  localparam logic [7:0] SW_LAST = 8'h08;
  // control word fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_FUNC_LSB = 4;
  localparam int CTRL_PORT_LSB = 8;
  localparam int CTRL_PIN_LSB = 12;
  localparam int CTRL_OPT_BIT = 15;
  // status word fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_BIT = 2;
  localparam int STAT_STEP_LSB = 4;
  // function codes
  localparam logic [3:0] FN_OUT_DIRECT = 4'h0;
  localparam logic [3:0] FN_INPUT = 4'h1;
  localparam logic [3:0] FN_ASYNC_TX = 4'h2;
  localparam logic [3:0] FN_SERIAL_BUS = 4'h3;
  localparam logic [3:0] FN_MAIN_CLOCK = 4'h4;
  localparam logic [3:0] FN_SUB_CLOCK = 4'h5;
  localparam logic [3:0] FN_RESET_PIN = 4'h6;
  localparam logic [3:0] FN_RELOCATE = 4'h7;
  localparam logic [3:0] FN_ANALOG = 4'h8;
  localparam logic [3:0] FN_LAST = 4'h8;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_WAIT,
    ST_MODIFY,
    ST_WRITE
  } paf_state_type;
endpackage

// [sim/paf_pin_setup_host_props.sv]
// checker: timing and content of the host's device accesses
`timescale 1ns/1ps
module paf_pin_setup_host_props
  import paf_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] devAddr,
  input wire logic [7:0] devWrData,
  input wire logic devWrite,
  input wire logic devRead
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // read, one quiet cycle, write back, no read straight after
  sequence sWriteBack;
    !devRead && !devWrite ##1 devWrite ##1 !devRead;
  endsequence
  AST_RD_THEN_WR: assert property (devRead |=> sWriteBack)
    else $error("write back missing after read");
  AST_WR_AFTER_RD: assert property (devWrite |-> $past(devRead, 2) && $stable(devAddr))
    else $error("write not on the address just read");
  AST_NO_BOTH: assert property (!(devRead && devWrite))
    else $error("read and write strobes together");
  AST_ADDR_HOLD: assert property (!devRead |-> $stable(devAddr))
    else $error("address moved without a read");
  AST_SERIAL_OD: assert property (devWrite && devAddr == ADDR_PORT_OUTPUT_MODE |-> devWrData[1:0] == 2'b11)
    else $error("serial bus pins not open drain");
  AST_CLOCK_MODE: assert property (devWrite && devAddr == ADDR_CLOCK_PIN_MODE |-> (devWrData & 8'h50) != 8'h00)
    else $error("clock pin mode write selects no mode");
  AST_ANALOG_A: assert property (devWrite && devAddr == ADDR_ANALOG_CFG_A |-> $past(devWrite, 4) && $past(devAddr, 4) == DIR_BASE + 16'h0002)
    else $error("config A written before direction");
  AST_ANALOG_B: assert property (devWrite && devAddr == ADDR_ANALOG_CFG_B |-> $past(devWrite, 4) && $past(devAddr, 4) == DIR_BASE + 16'h0001)
    else $error("config B written before direction");
endmodule
bind paf_pin_setup_host paf_pin_setup_host_props u_props (
  .clock(clock),
  .rstn(rstn),
  .devAddr(devAddr),
  .devWrData(devWrData),
  .devWrite(devWrite),
  .devRead(devRead)
);

// [sim/paf_dev_model.sv]
// partner: device register file answering the host's byte accesses
`timescale 1ns/1ps
module paf_dev_model
  import paf_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] devAddr,
  input wire logic [7:0] devWrData,
  input wire logic devWrite,
  input wire logic devRead,
  output logic [7:0] devRdData
);
  logic [7:0] mem [256];
  logic [7:0] lastRd;
  logic rdValid;
  // registers by low address byte; port directions reset to input
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= (i >= 32 && i < 40) ? 8'hFF : 8'h00;
      end
      mem[8'h2F] <= 8'h07;
      rdValid <= 1'b0;
      lastRd <= 8'h00;
    end else begin
      if (devWrite) begin
        mem[devAddr[7:0]] <= devWrData;
      end
      rdValid <= devRead;
      if (devRead) begin
        lastRd <= mem[devAddr[7:0]];
      end
    end
  end
  // answer only in the cycle after a read, inverted value elsewhere
  assign devRdData = rdValid ? lastRd : ~lastRd;
endmodule

// [sim/test_paf_pin_setup_host.sv]
// testbench: commands every pin function through the software port
`timescale 1ns/1ps
module test_paf_pin_setup_host
  import paf_pkg::*;
;
  logic clock, rstn, swWrite, swRead, devWrite, devRead;
  logic [7:0] swAddr, devWrData, devRdData, wrBase;
  logic [7:0] wrCount = 8'h00;
  logic [31:0] swWrData, swRdData, rd;
  logic [15:0] devAddr;
  logic [47:0] cases [12];
  int bad_count, tests_run;
  paf_pin_setup_host dut (.clock(clock), .rstn(rstn), .swAddr(swAddr),
    .swWrData(swWrData), .swWrite(swWrite), .swRead(swRead),
    .swRdData(swRdData), .devAddr(devAddr), .devWrData(devWrData),
    .devWrite(devWrite), .devRead(devRead), .devRdData(devRdData));
  paf_dev_model dev (.clock(clock), .rstn(rstn), .devAddr(devAddr),
    .devWrData(devWrData), .devWrite(devWrite), .devRead(devRead),
    .devRdData(devRdData));
  // clock and device write counter
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) if (devWrite === 1'b1) wrCount <= wrCount + 8'h01;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic swWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    swAddr <= a;
    swWrData <= d;
    swWrite <= 1'b1;
    @(posedge clock);
    swWrite <= 1'b0;
  endtask
  task automatic swRd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    swAddr <= a;
    swRead <= 1'b1;
    @(posedge clock);
    swRead <= 1'b0;
    #1 d = swRdData;
  endtask
  // clear flags, start, poll status for done or error
  task automatic runCmd(input logic [15:0] c);
    int n;
    swWr(SW_STATUS, 32'h6);
    swWr(SW_CTRL, {16'h0, c});
    n = 0;
    rd = 32'h0;
    while (rd[STAT_DONE_BIT] !== 1'b1 && rd[STAT_ERR_BIT] !== 1'b1 && n < 40) begin
      swRd(SW_STATUS, rd);
      n++;
    end
    if (n == 40) begin
      check(8'h00, 8'h01);
      end_of_test();
    end
  endtask
  // main sequence: control word, then two device registers and values
  initial begin
    {rstn, swWrite, swRead, swAddr, swWrData, wrBase} = '0;
    cases = '{48'h3121_0108_21F7, 48'h3101_0100_21F7, 48'h3111_21FF_0100,
      48'h8031_2A03_2903, 48'h8031_0603_26FC, 48'h8041_9FC0_9FC0,
      48'h0051_9FD0_9FD0, 48'h8061_2D20_2D20, 48'h0061_2D00_2D00,
      48'h8071_3F04_3F04, 48'h0281_2E00_22FF, 48'h1181_2F05_21FF};
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      runCmd(cases[i][47:32]);
      check(rd[7:0] & 8'h07, 8'h02);
      check(dev.mem[cases[i][31:24]], cases[i][23:16]);
      check(dev.mem[cases[i][15:8]], cases[i][7:0]);
      $display("test %0d done", i);
    end
    swRd(SW_LAST, rd);
    check(rd[7:0], 8'h07);
    // refused commands touch nothing
    wrBase = wrCount;
    runCmd(16'h0091);
    check(rd[7:0] & 8'h07, 8'h04);
    runCmd(16'h0381);
    check(rd[7:0] & 8'h07, 8'h04);
    check(wrCount, wrBase);
    swWr(SW_STATUS, 32'h4);
    swRd(SW_STATUS, rd);
    // step field still holds the two steps of the last analog command
    check(rd[7:0], 8'h20);
    swRd(8'h0C, rd);
    check(rd[7:0], 8'h00);
    $display("test refusals done");
    end_of_test();
  end
endmodule
